// ==== core/adcpc_map.svh ====
`ifndef ADCPC_MAP_SVH
`define ADCPC_MAP_SVH

// ==========================================================
// widths and timing
`define ADCPC_RES_W          10
`define ADCPC_CLK_NS         8
`define ADCPC_CONV_MAX_NS    6000
`define ADCPC_TRACK_MIN_NS   4000
`define ADCPC_CONV_MAX_CYC   (`ADCPC_CONV_MAX_NS / `ADCPC_CLK_NS)
`define ADCPC_TRACK_MIN_CYC  ((`ADCPC_TRACK_MIN_NS + `ADCPC_CLK_NS - 1) / `ADCPC_CLK_NS)
`define ADCPC_INT_DIV        8'h0f
`define ADCPC_ALL_ONES       10'h3ff
`define ADCPC_ALL_ZEROS      10'h000

`endif

// ==== core/adcpc_pkg.sv ====
`include "adcpc_map.svh"

package adcpc_pkg;

	typedef logic [`ADCPC_RES_W-1:0] adcpc_data_t;

	typedef enum logic [3:0] {
		ADCPC_TRACK = 4'h1,
		ADCPC_HOLD  = 4'h2,
		ADCPC_STEP  = 4'h4,
		ADCPC_DONE  = 4'h8
	} adcpc_state_t;

	typedef enum logic [4:0] {
		ADCPC_H_IDLE  = 5'h01,
		ADCPC_H_WR    = 5'h02,
		ADCPC_H_WAIT  = 5'h04,
		ADCPC_H_RD    = 5'h08,
		ADCPC_H_TRACK = 5'h10
	} adcpc_host_state_t;

endpackage

// ==== core/adcpc_if.sv ====
`timescale 1ns/1ps
`include "adcpc_map.svh"

interface adcpc_if;
	logic                        sel_n;
	logic                        wr_n;
	logic                        rd_n;
	logic                        done_n;
	logic [`ADCPC_RES_W-1:0]     data;
	logic [`ADCPC_RES_W-1:0]     data_oe;

	modport dev  (input sel_n, input wr_n, input rd_n, output done_n, output data, output data_oe);
	modport host (output sel_n, output wr_n, output rd_n, input done_n, input data, input data_oe);
endinterface

// ==== core/adcpc_device.sv ====
`timescale 1ns/1ps
// Overview of operation
// - strobes ignored unless select is low
// - selected write rising edge starts conversion, hold
// - track from done rising until next start
// - conversion steps itself on own clock
// - latch result and pull done low on the same clock edge
// - selected read raises done, drives result
// - conversion finishes within six microseconds
// - over range all ones, under all zeros
// - bus driven only during selected read
// - host tracks at least four microseconds
// - host decodes address into select
`include "adcpc_map.svh"
module adcpc_device
	import adcpc_pkg::*;
#(
	parameter int RES_W = `ADCPC_RES_W
) (
	// clock and reset
	input  wire logic                 MCLK_I,
	input  wire logic                 NRST_I,
	// host bus
	adcpc_if.dev                      bus,
	// converter side
	input  wire logic                 EXTERNAL_CLOCK_IN_I,
	input  wire logic                 USE_EXT_CLK_I,
	input  wire logic                 CMP_ABOVE_I,
	input  wire logic                 OVER_RANGE_I,
	input  wire logic                 UNDER_RANGE_I,
	output logic                      TRACK_O,
	output logic [RES_W-1:0]          TRIAL_O
);
	import adcpc_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [1:0] sel_s_reg, wr_s_reg, rd_s_reg, ck_s_reg;
	logic       wr_d_reg, ck_d_reg, sel_d_reg;
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			sel_s_reg <= 2'h3;
			wr_s_reg  <= 2'h3;
			rd_s_reg  <= 2'h3;
			ck_s_reg  <= 2'h0;
			wr_d_reg  <= 1'b1;
			ck_d_reg  <= 1'b0;
			sel_d_reg <= 1'b1;
		end else begin
			sel_s_reg <= {sel_s_reg[0], bus.sel_n};
			wr_s_reg  <= {wr_s_reg[0], bus.wr_n};
			rd_s_reg  <= {rd_s_reg[0], bus.rd_n};
			ck_s_reg  <= {ck_s_reg[0], EXTERNAL_CLOCK_IN_I};
			wr_d_reg  <= wr_s_reg[1];
			ck_d_reg  <= ck_s_reg[1];
			sel_d_reg <= sel_s_reg[1];
		end
	end

	logic sel, start, rd_act;
	assign sel    = !sel_s_reg[1];
	// select as it stood while the strobe was low: select may rise with the strobe
	assign start  = !sel_d_reg && wr_s_reg[1] && !wr_d_reg;
	assign rd_act = sel && !rd_s_reg[1];

	// ==========================================================
	// conversion step tick
	logic [7:0] div_reg;
	logic       tick;
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I)
			div_reg <= 8'h00;
		else if (div_reg == `ADCPC_INT_DIV)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end
	assign tick = USE_EXT_CLK_I ? (ck_s_reg[1] && !ck_d_reg) : (div_reg == `ADCPC_INT_DIV);

	// ==========================================================
	// sequencer
	adcpc_state_t      state_reg;
	logic [RES_W-1:0]  sar_reg, bit_reg, latch_reg;
	logic              done_n_reg;
	logic [15:0]       conv_cnt_reg;
	logic              timeout;
	// leaves room for the forced bits and the strobe synchroniser
	assign timeout = conv_cnt_reg >= 16'(`ADCPC_CONV_MAX_CYC - RES_W - 4);

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			state_reg    <= ADCPC_TRACK;
			sar_reg      <= '0;
			bit_reg      <= '0;
			conv_cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				ADCPC_TRACK: begin
					if (start) begin
						state_reg    <= ADCPC_HOLD;
						conv_cnt_reg <= 16'h0000;
					end
				end
				ADCPC_HOLD: begin
					sar_reg      <= {1'b1, {(RES_W-1){1'b0}}};
					bit_reg      <= {1'b1, {(RES_W-1){1'b0}}};
					state_reg    <= ADCPC_STEP;
					conv_cnt_reg <= conv_cnt_reg + 16'h0001;
				end
				ADCPC_STEP: begin
					conv_cnt_reg <= conv_cnt_reg + 16'h0001;
					if (tick || timeout) begin
						if (!CMP_ABOVE_I)
							sar_reg <= (sar_reg & ~bit_reg) | (bit_reg >> 1);
						else
							sar_reg <= sar_reg | (bit_reg >> 1);
						bit_reg <= bit_reg >> 1;
						if (bit_reg[0])
							state_reg <= ADCPC_DONE;
					end
				end
				ADCPC_DONE: begin
					if (rd_act && !done_n_reg)
						state_reg <= ADCPC_TRACK;
				end
				default: state_reg <= ADCPC_TRACK;
			endcase
		end
	end

	// ==========================================================
	// output latch and done flag
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I)
			latch_reg <= '0;
		else if (state_reg == ADCPC_DONE && done_n_reg) begin
			if (OVER_RANGE_I)
				latch_reg <= `ADCPC_ALL_ONES;
			else if (UNDER_RANGE_I)
				latch_reg <= `ADCPC_ALL_ZEROS;
			else
				latch_reg <= sar_reg;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!NRST_I)
			done_n_reg <= 1'b1;
		else if (state_reg == ADCPC_DONE && done_n_reg)
			done_n_reg <= 1'b0;
		else if (rd_act)
			done_n_reg <= 1'b1;
	end

	// ==========================================================
	// bus drive
	logic oe_reg;
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I)
			oe_reg <= 1'b0;
		else
			oe_reg <= rd_act;
	end

	assign bus.done_n  = done_n_reg;
	assign bus.data    = latch_reg;
	assign bus.data_oe = {RES_W{oe_reg}};
	assign TRACK_O     = (state_reg == ADCPC_TRACK);
	assign TRIAL_O     = sar_reg;

endmodule

// ==== core/adcpc_host.sv ====
`timescale 1ns/1ps
`include "adcpc_map.svh"

module adcpc_host
	import adcpc_pkg::*;
#(
	parameter int RES_W = `ADCPC_RES_W
) (
	// clock and reset
	input  wire logic                 MCLK_I,
	input  wire logic                 NRST_I,
	// device bus
	adcpc_if.host                     bus,
	// user side
	input  wire logic                 ADDR_HIT_I,
	input  wire logic                 START_I,
	output logic                      BUSY_O,
	output logic                      VALID_O,
	output adcpc_pkg::adcpc_data_t    RESULT_O
);
	import adcpc_pkg::*;

	// ==========================================================
	// synchronised done flag
	logic [1:0] done_s_reg;
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I)
			done_s_reg <= 2'h3;
		else
			done_s_reg <= {done_s_reg[0], bus.done_n};
	end

	// ==========================================================
	// access sequencer
	adcpc_host_state_t st_reg;
	logic [15:0]       cnt_reg;
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			st_reg  <= ADCPC_H_TRACK;
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			case (st_reg)
				ADCPC_H_TRACK: begin
					if (cnt_reg >= 16'(`ADCPC_TRACK_MIN_CYC))
						st_reg <= ADCPC_H_IDLE;
				end
				ADCPC_H_IDLE: begin
					cnt_reg <= 16'h0000;
					if (START_I && ADDR_HIT_I)
						st_reg <= ADCPC_H_WR;
				end
				ADCPC_H_WR: begin
					if (cnt_reg == 16'h0007) begin
						st_reg  <= ADCPC_H_WAIT;
						cnt_reg <= 16'h0000;
					end
				end
				ADCPC_H_WAIT: begin
					cnt_reg <= 16'h0000;
					if (!done_s_reg[1])
						st_reg <= ADCPC_H_RD;
				end
				ADCPC_H_RD: begin
					if (cnt_reg == 16'h0007) begin
						st_reg  <= ADCPC_H_TRACK;
						cnt_reg <= 16'h0000;
					end
				end
				default: st_reg <= ADCPC_H_TRACK;
			endcase
		end
	end

	// ==========================================================
	// result capture
	always_ff @(posedge MCLK_I) begin
		if (!NRST_I) begin
			RESULT_O <= '0;
			VALID_O  <= 1'b0;
		end else begin
			VALID_O <= 1'b0;
			if (st_reg == ADCPC_H_RD && cnt_reg == 16'h0006) begin
				RESULT_O <= bus.data;
				VALID_O  <= 1'b1;
			end
		end
	end

	assign bus.sel_n = !(st_reg == ADCPC_H_WR || st_reg == ADCPC_H_RD);
	assign bus.wr_n  = !(st_reg == ADCPC_H_WR);
	assign bus.rd_n  = !(st_reg == ADCPC_H_RD);
	assign BUSY_O    = (st_reg != ADCPC_H_IDLE);

endmodule

// ==== sim/adcpc_monitor.sv ====
`timescale 1ns/1ps
`include "adcpc_map.svh"
// ====================
// bus checker
module adcpc_monitor (
	// clock and reset
	input  wire logic                    MCLK_I,
	input  wire logic                    NRST_I,
	// bus
	input  wire logic                    sel_n,
	input  wire logic                    wr_n,
	input  wire logic                    rd_n,
	input  wire logic                    done_n,
	input  wire logic [`ADCPC_RES_W-1:0] data,
	input  wire logic [`ADCPC_RES_W-1:0] data_oe
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);
	sequence start_s;
		$rose(wr_n) && $past(!sel_n);
	endsequence
	sequence read_s;
		$fell(rd_n) && !sel_n;
	endsequence
	chk_conv_time: assert property (start_s |-> ##[1:760] $fell(done_n))
		else $error("no done after start");
	chk_read_clears: assert property (read_s and !done_n |-> ##[1:4] done_n)
		else $error("done not cleared");
	chk_done_holds: assert property ((!done_n && rd_n)[*4] |=> !done_n)
		else $error("done dropped early");
	chk_rise_by_read: assert property ($rose(done_n) |-> $past(!rd_n, 2) || $past(!rd_n, 4))
		else $error("done rose without read");
	chk_oe_cause: assert property ($rose(|data_oe) |-> $past(!sel_n && !rd_n, 2))
		else $error("bus driven without read");
	chk_oe_release: assert property ($rose(rd_n) |-> ##[1:4] data_oe == '0)
		else $error("bus not released");
	chk_oe_whole: assert property (data_oe == '0 || data_oe == '1)
		else $error("partial drive");
	chk_data_steady: assert property ((|data_oe) && $past(|data_oe) |-> $stable(data))
		else $error("data moved in read");
endmodule

// ==== sim/test_adc_parallel_conversion_control.sv ====
`timescale 1ns/1ps
// ====================
// conversion bench
module test_adc_parallel_conversion_control;
	import adcpc_pkg::*;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ext_clk = 1'b0;
	logic        use_ext = 1'b0;
	logic        cmp = 1'b0;
	logic        over = 1'b0;
	logic        under = 1'b0;
	logic        hit = 1'b0;
	logic        start = 1'b0;
	logic        busy, valid, trk, trk_b;
	logic [1:0]  mode;
	adcpc_data_t result, trial, trial_b, nv;
	adcpc_data_t v = '0;
	adcpc_data_t q[$];
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          seed = 32'h7a93;
	int          ck = 0;
	int          i, n;
	adcpc_if bus ();
	adcpc_if fb ();
	always #4 mclk = ~mclk;
	adcpc_host i_adcpc_host (.MCLK_I(mclk), .NRST_I(nrst), .bus(bus), .ADDR_HIT_I(hit), .START_I(start),
		.BUSY_O(busy), .VALID_O(valid), .RESULT_O(result));
	adcpc_device i_adcpc_device (.MCLK_I(mclk), .NRST_I(nrst), .bus(bus), .EXTERNAL_CLOCK_IN_I(ext_clk),
		.USE_EXT_CLK_I(use_ext), .CMP_ABOVE_I(cmp), .OVER_RANGE_I(over), .UNDER_RANGE_I(under),
		.TRACK_O(trk), .TRIAL_O(trial));
	adcpc_device i_adcpc_device_b (.MCLK_I(mclk), .NRST_I(nrst), .bus(fb), .EXTERNAL_CLOCK_IN_I(ext_clk),
		.USE_EXT_CLK_I(use_ext), .CMP_ABOVE_I(cmp), .OVER_RANGE_I(over), .UNDER_RANGE_I(under),
		.TRACK_O(trk_b), .TRIAL_O(trial_b));
	adcpc_monitor i_adcpc_monitor (.MCLK_I(mclk), .NRST_I(nrst), .sel_n(bus.sel_n), .wr_n(bus.wr_n),
		.rd_n(bus.rd_n), .done_n(bus.done_n), .data(bus.data), .data_oe(bus.data_oe));
	task automatic check(input string name, input adcpc_data_t seen, input adcpc_data_t exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic timeout();
		n_mismatch++;
		finish_test();
	endtask
	// strobe on the second bus, held eight cycles
	task automatic fstrobe(input logic s, input logic w);
		fb.sel_n <= s;
		fb.wr_n <= !w;
		fb.rd_n <= w;
		repeat (8) @(negedge mclk);
		fb.sel_n <= 1'b1;
		fb.wr_n <= 1'b1;
		fb.rd_n <= 1'b1;
		repeat (6) @(negedge mclk);
	endtask
	// comparator and external step clock
	always @(negedge mclk) begin
		ck <= (ck == 14) ? 0 : ck + 1;
		if (ck == 14) begin
			ext_clk <= ~ext_clk;
		end
		cmp <= (v >= trial);
	end
	// result watcher
	always @(negedge mclk) begin
		if (valid === 1'b1) begin
			if (q.size() == 0) begin
				check("stray valid", {9'h0, valid}, 10'h0);
			end else begin
				check("result", result, q.pop_front());
				check("tracking after read", {9'h0, trk}, 10'h1);
			end
		end
		if (bus.data_oe === 10'h3ff && q.size() > 0) begin
			check("bus data", bus.data, q[0]);
		end
	end
	initial begin
		fb.sel_n = 1'b1;
		fb.wr_n = 1'b1;
		fb.rd_n = 1'b1;
		repeat (20) @(negedge mclk);
		nrst <= 1'b1;
		fstrobe(1'b1, 1'b1);
		fstrobe(1'b1, 1'b0);
		repeat (760) @(negedge mclk);
		check("unselected write", {9'h0, fb.done_n}, 10'h1);
		fstrobe(1'b0, 1'b1);
		for (i = 0; i < 750 && fb.done_n !== 1'b0; i++) @(negedge mclk);
		check("done set", {9'h0, fb.done_n}, 10'h0);
		check("hold until read", {9'h0, trk_b}, 10'h0);
		fstrobe(1'b1, 1'b0);
		check("unselected read", {9'h0, fb.done_n}, 10'h0);
		fstrobe(1'b0, 1'b0);
		check("read clears", {9'h0, fb.done_n}, 10'h1);
		check("track after read", {9'h0, trk_b}, 10'h1);
		check("oe released", fb.data_oe, 10'h0);
		for (n = 0; n < 12; n++) begin
			for (i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk);
			if (i == 2000) timeout();
			mode = n[1:0];
			nv = (mode == 2'h0 && n < 8) ? {10{n[2]}} : adcpc_data_t'($random(seed));
			v <= nv;
			use_ext <= n[2];
			over <= mode[0];
			under <= mode[1];
			q.push_back(mode[0] ? 10'h3ff : (mode[1] ? 10'h000 : nv));
			start <= 1'b1;
			repeat (4) @(negedge mclk);
			check("miss busy", {9'h0, busy}, 10'h0);
			hit <= 1'b1;
			@(negedge mclk);
			start <= 1'b0;
			hit <= 1'b0;
			for (i = 0; i < 2000 && q.size() > 0; i++) @(negedge mclk);
			if (i == 2000) timeout();
		end
		finish_test();
	end
endmodule
